// ### include/acal_pkg.sv
// constants and types shared by the calibration engine and its divider
package acal_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_OFS0 = 5'h07;
  localparam logic [4:0] ADDR_OFS1 = 5'h08;
  localparam logic [4:0] ADDR_OFS2 = 5'h09;
  localparam logic [4:0] ADDR_GAIN0 = 5'h0A;
  localparam logic [4:0] ADDR_GAIN1 = 5'h0B;
  localparam logic [4:0] ADDR_GAIN2 = 5'h0C;
  localparam logic [23:0] OFS_RST = 24'h000000;
  localparam logic [23:0] GAIN_UNITY = 24'h400000;
  localparam int GAIN_SHIFT = 22;
  localparam logic [23:0] POS_FULL = 24'h7FFFFF;
  localparam logic [23:0] NEG_FULL = 24'h800000;
  localparam logic [23:0] GAIN_MAX = 24'hFFFFFF;

  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_START = 8'h01;
  localparam logic [7:0] OP_STOP = 8'h02;
  localparam logic [7:0] OP_SELF_CAL = 8'h11;
  localparam logic [7:0] OP_SYS_CAL = 8'h12;
  localparam logic [7:0] OP_FS_CAL = 8'h13;
  localparam logic [2:0] OP_WREG_TOP = 3'h2;

  // ----------------------------------------------------------------
  // calibration arithmetic
  // ----------------------------------------------------------------
  localparam int AVG_LOG2 = 4;
  localparam int DIV_NW = 46;
  localparam int DIV_DW = 25;
  localparam logic [DIV_NW-1:0] FS_NUM = 46'h1FFFFFC00000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] data;
  } acal_cmd_t;

  typedef enum logic [1:0] {
    KIND_SELF,
    KIND_SYS,
    KIND_FS
  } acal_kind_t;

endpackage : acal_pkg

// ### src/acal_div.sv
// restoring divider used to compute the full-scale correction word
`timescale 1ns/10ps
module acal_div
  import acal_pkg::*;
#(
  parameter int NW = DIV_NW,
  parameter int DW = DIV_DW
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic busy,
  output logic done,
  output logic [NW-1:0] quo
);

  localparam int CNT_W = $clog2(NW + 1);

  logic [DW-1:0] rem_ff;
  logic [NW-1:0] quo_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  // ----------------------------------------------------------------
  // one quotient bit per cycle
  // ----------------------------------------------------------------
  wire [DW:0] shifted = {rem_ff, quo_ff[NW-1]};
  wire [DW+1:0] trial = {1'b0, shifted} - {2'b00, den};
  wire fits = ~trial[DW+1];
  wire [DW-1:0] nxt_rem = fits ? trial[DW-1:0] : shifted[DW-1:0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rem_ff <= '0;
      quo_ff <= '0;
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (go)
    begin
      rem_ff <= '0;
      quo_ff <= num;
      cnt_ff <= CNT_W'(NW);
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else if (busy_ff)
    begin
      rem_ff <= nxt_rem;
      quo_ff <= {quo_ff[NW-2:0], fits};
      cnt_ff <= cnt_ff - 1'b1;
      busy_ff <= (cnt_ff != 1);
      done_ff <= (cnt_ff == 1);
    end
    else
    begin
      done_ff <= 1'b0;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
  assign quo = quo_ff;

endmodule : acal_div

// ### src/acal_engine.sv
// offset and full-scale calibration engine with its serial command port
`timescale 1ns/10ps

// Summary of operation
// R1 - result is (filter minus offset) times gain over 400000h, clipped to 24 bits
// R2 - gain word is 24-bit unsigned over three bytes, 400000h is unity
// R3 - offset word is 24-bit two's complement at 07h..09h, zero means none
// R4 - self offset cal opens inputs, shorts amplifier, averages 16 conversions
// R5 - after self offset cal, inputs return and one corrected conversion runs
// R6 - system offset cal averages 16 shorted conversions, stores, converts once
// R7 - full-scale cal averages 16 conversions, derives gain, converts once more
// R8 - host applies and settles a positive full-scale voltage beforehand
// R9 - host keeps register lock unlocked for every calibration command
// R10 - host calibrates offset before gain, after the reference has settled
// R11 - start pin or start command begins conversions, ready output goes high
// R12 - command sent before conversion ends; chip select high cancels it
// R13 - host sends no other command while calibration runs
// R14 - on completion, registers update, ready goes low with corrected data
// R15 - calibration time follows data rate and filter type
// R16 - host presets offset zero and gain unity before user calibration
// R17 - user offset cal: host averages shorted results, writes offset word
// R18 - user gain cal: host uses 3CCCCCh and writes 799998h over measured
// R19 - serial port is mode 1: clock idles low, sample on falling edge
// R20 - host holds chip select low per transaction, returns clock low
// R21 - chip select high resets port, ignores clock, releases data-out pin
// R22 - commands and write data are sampled on falling serial clock edges
// R23 - ready output stays high through the whole calibration
module acal_engine
  import acal_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic start_pin,
  input wire logic [23:0] filt_data,
  input wire logic filt_valid,
  output logic conv_run,
  output logic filt_restart,
  output logic in_disconnect,
  output logic in_short,
  output logic conversion_ready_n,
  output logic [23:0] result_data,
  output logic [23:0] offset_corr_word,
  output logic [23:0] gain_corr_word,
  output logic cal_busy,
  output logic shared_data_out_pin_o,
  output logic shared_data_out_pin_oe
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_AVG,
    ST_DIV,
    ST_CONV
  } acal_state_t;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic [1:0] cs_sync_ff;
  logic [1:0] start_sync_ff;
  logic start_d_ff;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  assign rst_sync_n = rst_sync_ff[1];

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cs_sync_ff <= 2'h3;
      start_sync_ff <= 2'h0;
      start_d_ff <= 1'b0;
    end
    else
    begin
      cs_sync_ff <= {cs_sync_ff[0], cs_n};
      start_sync_ff <= {start_sync_ff[0], start_pin};
      start_d_ff <= start_sync_ff[1];
    end
  end

  wire cs_high = cs_sync_ff[1];
  wire start_rise = start_sync_ff[1] & ~start_d_ff;
  wire start_fall = ~start_sync_ff[1] & start_d_ff;

  // ----------------------------------------------------------------
  // serial link, clocked by the serial clock
  // ----------------------------------------------------------------
  // chip select high clears the shift register, bit count and opcode at once, so a torn byte
  // can never be completed by a later clock
  wire link_clr = cs_n | ~rst_n;

  logic [6:0] sh_ff;
  logic [2:0] bit_ff;
  logic second_ff;
  logic [7:0] op_ff;
  acal_cmd_t word_ff;
  logic req_tgl_ff;

  wire [7:0] rx_byte = {sh_ff, din};
  wire byte_end = (bit_ff == 3'h7);
  wire is_wreg = (rx_byte[7:5] == OP_WREG_TOP);

  always_ff @(negedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      sh_ff <= 7'h00;
      bit_ff <= 3'h0;
      second_ff <= 1'b0;
      op_ff <= 8'h00;
    end
    else
    begin
      sh_ff <= rx_byte[6:0]; // R19 R22
      bit_ff <= bit_ff + 3'h1;
      if (byte_end)
      begin
        second_ff <= ~second_ff & is_wreg;
        op_ff <= rx_byte;
      end
    end
  end

  // the posted word and its toggle survive chip select so that the
  // core never sees a half-updated word
  always_ff @(negedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_ff <= '0;
      req_tgl_ff <= 1'b0;
    end
    else if (!cs_n && byte_end && (second_ff || !is_wreg))
    begin
      word_ff <= second_ff ? {op_ff, rx_byte} : {rx_byte, 8'h00}; // R22
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  // the data-out pin only reports conversion ready while selected
  assign shared_data_out_pin_o = conversion_ready_n;
  assign shared_data_out_pin_oe = ~cs_n; // R21

  // ----------------------------------------------------------------
  // command crossing into the converter clock
  // ----------------------------------------------------------------
  logic [2:0] req_sync_ff;
  acal_cmd_t cmd_ff;
  logic cmd_vld_ff;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      req_sync_ff <= 3'h0;
      cmd_ff <= '0;
      cmd_vld_ff <= 1'b0;
    end
    else
    begin
      req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
      cmd_vld_ff <= req_sync_ff[2] ^ req_sync_ff[1];
      if (req_sync_ff[2] ^ req_sync_ff[1])
        cmd_ff <= word_ff;
    end
  end

  wire [4:0] wr_addr = cmd_ff.op[4:0];
  wire cmd_wreg = cmd_vld_ff & (cmd_ff.op[7:5] == OP_WREG_TOP);
  wire cmd_start = cmd_vld_ff & (cmd_ff.op == OP_START);
  wire cmd_stop = cmd_vld_ff & (cmd_ff.op == OP_STOP);
  wire cmd_self = cmd_vld_ff & (cmd_ff.op == OP_SELF_CAL);
  wire cmd_sys = cmd_vld_ff & (cmd_ff.op == OP_SYS_CAL);
  wire cmd_fs = cmd_vld_ff & (cmd_ff.op == OP_FS_CAL);
  wire cmd_cal = cmd_self | cmd_sys | cmd_fs;

  // ----------------------------------------------------------------
  // correction datapath
  // ----------------------------------------------------------------
  logic [23:0] ofs_ff;
  logic [23:0] gain_ff;

  function automatic logic [23:0] clip24(input logic [27:0] v);
    if (!v[27] && (v[26:23] != 4'h0))
      clip24 = POS_FULL;
    else if (v[27] && (v[26:23] != 4'hF))
      clip24 = NEG_FULL;
    else
      clip24 = v[23:0];
  endfunction : clip24

  wire signed [24:0] diff = $signed({filt_data[23], filt_data})
    - $signed({ofs_ff[23], ofs_ff}); // R1 R3
  wire signed [49:0] prod = diff * $signed({1'b0, gain_ff}); // R1 R2
  wire [27:0] scaled = prod[GAIN_SHIFT+27:GAIN_SHIFT];
  wire [23:0] corrected = clip24(scaled); // R1

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  acal_state_t state_ff;
  acal_state_t nxt_state;
  acal_kind_t kind_ff;
  logic run_cmd_ff;
  logic [AVG_LOG2-1:0] avg_cnt_ff;
  logic [27:0] acc_ff;
  logic conversion_ready_n_n_ff;
  logic [23:0] result_ff;
  logic restart_ff;
  logic div_go_ff;
  logic div_busy;
  logic div_done;
  logic [DIV_NW-1:0] div_quo;
  logic signed [24:0] fs_den_ff;

  wire in_cal = (state_ff == ST_AVG) || (state_ff == ST_DIV)
    || (state_ff == ST_CONV);
  wire running = run_cmd_ff | start_sync_ff[1];
  wire avg_last = filt_valid && (avg_cnt_ff == '1);
  wire [27:0] acc_sum = acc_ff + {{4{filt_data[23]}}, filt_data};
  wire [23:0] avg_val = acc_sum[AVG_LOG2+23:AVG_LOG2];
  wire signed [24:0] fs_den = $signed({avg_val[23], avg_val})
    - $signed({ofs_ff[23], ofs_ff});
  // the divider reads a held copy: the live average moves on after the
  // sixteenth result and would corrupt the quotient
  wire fs_den_bad = (fs_den_ff <= 0);
  wire [23:0] gain_new = (fs_den_bad || (div_quo[DIV_NW-1:24] != '0))
    ? GAIN_MAX : div_quo[23:0];

  // a calibration is accepted while idle or converting; while one is
  // in progress every further command is dropped, but a start command still pulses filt_restart
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE, ST_RUN:
        if (cmd_cal)
          nxt_state = ST_AVG; // R12
        else if (!running || cmd_stop || start_fall)
          nxt_state = ST_IDLE;
        else
          nxt_state = ST_RUN; // R11
      ST_AVG:
        if (avg_last)
          nxt_state = (kind_ff == KIND_FS) ? ST_DIV : ST_CONV; // R4 R6 R7
      ST_DIV:
        if (div_done)
          nxt_state = ST_CONV; // R7
      ST_CONV:
        if (filt_valid)
          nxt_state = running ? ST_RUN : ST_IDLE; // R5 R14
    endcase
    if (in_cal && cs_high)
      nxt_state = running ? ST_RUN : ST_IDLE; // R12
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_ff <= ST_IDLE;
      kind_ff <= KIND_SELF;
      run_cmd_ff <= 1'b0;
      avg_cnt_ff <= '0;
      acc_ff <= 28'h0000000;
    end
    else
    begin
      state_ff <= nxt_state;
      if (cmd_start && !in_cal)
        run_cmd_ff <= 1'b1; // R11
      else if (cmd_stop && !in_cal)
        run_cmd_ff <= 1'b0; // R13
      if (cmd_cal && !in_cal)
        kind_ff <= cmd_self ? KIND_SELF : (cmd_sys ? KIND_SYS : KIND_FS);
      if (state_ff != ST_AVG)
      begin
        avg_cnt_ff <= '0;
        acc_ff <= 28'h0000000;
      end
      else if (filt_valid)
      begin
        avg_cnt_ff <= avg_cnt_ff + 1'b1; // R4 R6 R7 R15
        acc_ff <= acc_sum;
      end
    end
  end

  // ----------------------------------------------------------------
  // correction registers: host writes and calibration results
  // ----------------------------------------------------------------
  wire wr_en = cmd_wreg && !in_cal; // R13
  wire ofs_cal_wr = (state_ff == ST_AVG) && avg_last
    && (kind_ff != KIND_FS) && !cs_high; // R12
  wire gain_cal_wr = (state_ff == ST_DIV) && div_done && !cs_high; // R12

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ofs_ff <= OFS_RST;
      gain_ff <= GAIN_UNITY;
    end
    else
    begin
      if (ofs_cal_wr)
        ofs_ff <= avg_val; // R3 R4 R6 R14
      else if (wr_en && wr_addr == ADDR_OFS0)
        ofs_ff[7:0] <= cmd_ff.data;
      else if (wr_en && wr_addr == ADDR_OFS1)
        ofs_ff[15:8] <= cmd_ff.data;
      else if (wr_en && wr_addr == ADDR_OFS2)
        ofs_ff[23:16] <= cmd_ff.data;
      if (gain_cal_wr)
        gain_ff <= gain_new; // R2 R7 R14
      else if (wr_en && wr_addr == ADDR_GAIN0)
        gain_ff[7:0] <= cmd_ff.data;
      else if (wr_en && wr_addr == ADDR_GAIN1)
        gain_ff[15:8] <= cmd_ff.data;
      else if (wr_en && wr_addr == ADDR_GAIN2)
        gain_ff[23:16] <= cmd_ff.data;
    end
  end

  acal_div #(
    .NW(DIV_NW),
    .DW(DIV_DW)
  ) u_div (
    .clk(mclk),
    .rst_n(rst_sync_n),
    .go(div_go_ff),
    .num(FS_NUM),
    .den(fs_den_ff),
    .busy(div_busy),
    .done(div_done),
    .quo(div_quo)
  );

  // ----------------------------------------------------------------
  // results, conversion ready and input switching
  // ----------------------------------------------------------------
  wire conv_begin = (nxt_state != ST_IDLE) && (state_ff != nxt_state)
    && !(state_ff == ST_AVG && nxt_state == ST_DIV);

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      conversion_ready_n_n_ff <= 1'b1;
      result_ff <= 24'h000000;
      restart_ff <= 1'b0;
      div_go_ff <= 1'b0;
      fs_den_ff <= '0;
    end
    else
    begin
      restart_ff <= conv_begin || start_rise || cmd_start;
      div_go_ff <= (state_ff == ST_AVG) && avg_last && (kind_ff == KIND_FS);
      if ((state_ff == ST_AVG) && avg_last)
        fs_den_ff <= fs_den; // R7
      if (conv_begin || start_rise || cmd_start || in_cal)
        conversion_ready_n_n_ff <= 1'b1; // R11 R23
      else if (filt_valid && state_ff == ST_RUN)
        conversion_ready_n_n_ff <= 1'b0;
      if (state_ff == ST_CONV && filt_valid && !cs_high)
      begin
        conversion_ready_n_n_ff <= 1'b0; // R14
        result_ff <= corrected; // R5 R14
      end
      else if (state_ff == ST_RUN && filt_valid)
        result_ff <= corrected; // R1
    end
  end

  assign conv_run = (state_ff != ST_IDLE);
  assign filt_restart = restart_ff;
  assign in_disconnect = (state_ff == ST_AVG) && (kind_ff == KIND_SELF); // R4
  assign in_short = (state_ff == ST_AVG) && (kind_ff == KIND_SELF); // R4 R5
  assign conversion_ready_n = conversion_ready_n_n_ff;
  assign result_data = result_ff;
  assign offset_corr_word = ofs_ff;
  assign gain_corr_word = gain_ff;
  assign cal_busy = in_cal;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_avg_done;
    (state_ff == ST_AVG) && avg_last && !cs_high;
  endsequence

  sequence s_conv_done;
    (state_ff == ST_CONV) && filt_valid && !cs_high;
  endsequence

  a_ready_high_cal: assert property ( // R23
    (state_ff == ST_AVG) |=> conversion_ready_n)
    else $error("ready fell during averaging");
  a_self_inputs: assert property ( // R4
    (state_ff == ST_AVG && kind_ff == KIND_SELF) |-> in_short && in_disconnect)
    else $error("self calibration inputs not isolated");
  a_inputs_back: assert property ( // R5
    (state_ff == ST_CONV) |-> !in_short && !in_disconnect)
    else $error("inputs still shorted in final conversion");
  a_offset_store: assert property ( // R6
    (s_avg_done and (kind_ff != KIND_FS)) |=>
      (ofs_ff == $past(avg_val)) && (state_ff == ST_CONV))
    else $error("offset average not stored");
  a_gain_store: assert property ( // R7
    ((state_ff == ST_DIV) && div_done && !cs_high) |=>
      (gain_ff == $past(gain_new)) && (state_ff == ST_CONV))
    else $error("gain word not stored");
  a_div_bounded: assert property ( // R7
    s_avg_done and (kind_ff == KIND_FS) |-> ##[2:60] (state_ff != ST_DIV))
    else $error("divider did not finish");
  a_cal_finish: assert property ( // R14
    s_conv_done |=> !conversion_ready_n && !cal_busy
      && (result_data == $past(corrected)))
    else $error("calibration end not reported");
  a_cs_cancel: assert property ( // R12
    (in_cal && cs_high) |=> !cal_busy)
    else $error("chip select did not cancel calibration");
  a_start_ready: assert property ( // R11
    (start_rise && !in_cal) |=> conversion_ready_n && filt_restart)
    else $error("start did not raise ready");
  a_pin_release: assert property ( // R21
    cs_n |-> !shared_data_out_pin_oe)
    else $error("data-out driven while deselected");
  a_avg_sixteen: assert property ( // R4
    (state_ff == ST_AVG && filt_valid && avg_cnt_ff != '1)
      |=> (state_ff == ST_AVG) || (state_ff == ST_RUN)
      || (state_ff == ST_IDLE))
    else $error("averaging left before sixteen results");

endmodule : acal_engine

// ### sim/acal_host_model.sv
// host controller model driving the serial command port
`timescale 1ns/10ps
module acal_host_model
(
  output logic sclk,
  output logic cs_n,
  output logic din
);
  localparam time HALF = 24;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // ------------------------------------------------------------
  // frame control
  // ------------------------------------------------------------
  task automatic select();
    cs_n = 1'b0;
    #HALF;
  endtask : select

  // a cal frame must stay selected until the cal is over
  task automatic release_bus();
    #HALF;
    cs_n = 1'b1;
    din = ~din;
  endtask : release_bus

  // ------------------------------------------------------------
  // byte transfer, msb first, clock idles low between frames
  // ------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b1;
      din = b[i];
      #HALF;
      sclk = 1'b0;
      #HALF;
    end
    // hold time over: do not leave the last bit on the line
    din = ~din;
  endtask : send_byte
endmodule : acal_host_model

// ### sim/adc_calibration_engine_tb.sv
// self-checking testbench for the calibration engine
`timescale 1ns/10ps
module adc_calibration_engine_tb;
  import acal_pkg::*;
  logic mclk, rst_n, start_pin, filt_valid;
  logic [23:0] filt_data;
  logic sclk, cs_n, din, conv_run, filt_restart, in_disconnect, in_short;
  logic conversion_ready_n, cal_busy, dout_o, dout_oe;
  logic [23:0] result_data, offset_corr_word, gain_corr_word;
  int n_fail = 0;
  int check_count = 0;

  acal_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din));

  acal_engine uut (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .start_pin(start_pin), .filt_data(filt_data),
    .filt_valid(filt_valid), .conv_run(conv_run),
    .filt_restart(filt_restart), .in_disconnect(in_disconnect),
    .in_short(in_short), .conversion_ready_n(conversion_ready_n),
    .result_data(result_data), .offset_corr_word(offset_corr_word),
    .gain_corr_word(gain_corr_word), .cal_busy(cal_busy),
    .shared_data_out_pin_o(dout_o), .shared_data_out_pin_oe(dout_oe)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen,
                     input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // positive products only, so floor and truncation agree
  function automatic logic [23:0] exp_res(input logic [23:0] f, o, g);
    longint d;
    d = (longint'($signed(f)) - longint'($signed(o))) * longint'(g);
    d = d >>> GAIN_SHIFT;
    if (d > 64'sh7FFFFF) return POS_FULL;
    if (d < -64'sh800000) return NEG_FULL;
    return d[23:0];
  endfunction : exp_res

  task automatic feed(input logic [23:0] v);
    @(negedge mclk);
    filt_valid = 1'b1;
    filt_data = v;
    @(negedge mclk);
    filt_valid = 1'b0;
    filt_data = ~v;
    repeat (2) @(negedge mclk);
  endtask : feed

  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    host.select();
    host.send_byte({OP_WREG_TOP, a});
    host.send_byte(d);
    host.release_bus();
    repeat (8) @(negedge mclk);
  endtask : wreg

  task automatic cmd1(input logic [7:0] op);
    host.select();
    host.send_byte(op);
    host.release_bus();
    repeat (8) @(negedge mclk);
  endtask : cmd1

  task automatic set_words(input logic [23:0] o, input logic [23:0] g);
    for (int i = 0; i < 3; i++)
    begin
      wreg(5'(ADDR_OFS0 + i), o[8*i+:8]);
      wreg(5'(ADDR_GAIN0 + i), g[8*i+:8]);
    end
  endtask : set_words

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (cal_busy !== v && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    chk("cal_busy", 24'(cal_busy), 24'(v));
  endtask : wait_busy

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("ofs rst", offset_corr_word, OFS_RST);
    chk("gain rst", gain_corr_word, GAIN_UNITY);
    chk("oe idle", 24'(dout_oe), 24'h0);
  endtask : t_reset

  task automatic t_regs();
    set_words(24'h123456, 24'h3CCCCC);
    chk("ofs word", offset_corr_word, 24'h123456);
    chk("gain word", gain_corr_word, 24'h3CCCCC);
    wreg(5'h0D, 8'hA5);
    chk("unmapped", gain_corr_word, 24'h3CCCCC);
    host.select();
    chk("oe sel", 24'(dout_oe), 24'h1);
    chk("dout", 24'(dout_o), 24'(conversion_ready_n));
    host.release_bus();
  endtask : t_regs

  task automatic t_conv();
    set_words(24'h000010, 24'h3CCCCC);
    start_pin = 1'b1;
    repeat (6) @(negedge mclk);
    feed(24'h100010);
    chk("res", result_data, exp_res(24'h100010, 24'h10, 24'h3CCCCC));
    chk("rdy", 24'(conversion_ready_n), 24'h0);
    wreg(ADDR_GAIN2, 8'h43);
    feed(24'h7FFFF0);
    chk("clip hi", result_data, POS_FULL);
    feed(24'h800000);
    chk("clip lo", result_data, NEG_FULL);
    start_pin = 1'b0;
    repeat (4) @(negedge mclk);
    chk("run off", 24'(conv_run), 24'h0);
    cmd1(OP_START);
    chk("run cmd", 24'(conv_run), 24'h1);
    chk("rdy cmd", 24'(conversion_ready_n), 24'h1);
    cmd1(OP_STOP);
    chk("run stop", 24'(conv_run), 24'h0);
    start_pin = 1'b1;
    repeat (6) @(negedge mclk);
    chk("rdy start", 24'(conversion_ready_n), 24'h1);
    chk("run on", 24'(conv_run), 24'h1);
  endtask : t_conv

  // user calibration: the host averages raw codes and writes the words
  task automatic t_user_cal();
    logic [23:0] avg;
    longint g;
    set_words(OFS_RST, GAIN_UNITY);
    feed(24'h000030);
    chk("raw", result_data, 24'h000030);
    avg = result_data;
    feed(24'h000050);
    avg = 24'((longint'(avg) + longint'(result_data)) / 2);
    set_words(avg, 24'h3CCCCC);
    chk("user ofs", offset_corr_word, 24'h000040);
    feed(24'h7C0040);
    chk("user raw", result_data, exp_res(24'h7C0040, avg, 24'h3CCCCC));
    g = (longint'(24'h799998) * longint'(GAIN_UNITY)) / longint'(result_data);
    set_words(avg, 24'(g));
    feed(24'h7C0040);
    chk("user res", result_data, exp_res(24'h7C0040, avg, 24'(g)));
  endtask : t_user_cal

  // self and system offset cal differ only in the input switches
  task automatic t_ofs_cal(input logic [7:0] op, input logic sh);
    set_words(OFS_RST, GAIN_UNITY);
    host.select();
    host.send_byte(op);
    wait_busy(1'b1);
    chk("short", 24'(in_short), 24'(sh));
    chk("open", 24'(in_disconnect), 24'(sh));
    for (int i = 0; i < 16; i++)
    begin
      feed(24'h0001F8 + (i[0] ? 24'h10 : 24'h0));
      chk("rdy cal", 24'(conversion_ready_n), 24'h1);
    end
    chk("ofs avg", offset_corr_word, 24'h000200);
    chk("short off", 24'(in_short), 24'h0);
    feed(24'h000300);
    chk("res cal", result_data, 24'h000100);
    chk("rdy end", 24'(conversion_ready_n), 24'h0);
    chk("busy end", 24'(cal_busy), 24'h0);
    host.release_bus();
  endtask : t_ofs_cal

  task automatic t_fs_cal();
    host.select();
    host.send_byte(OP_FS_CAL);
    wait_busy(1'b1);
    for (int i = 0; i < 16; i++)
      feed(24'h400200);
    repeat (60) @(negedge mclk);
    chk("gain cal", gain_corr_word, 24'h7FFFFF);
    chk("rdy fs", 24'(conversion_ready_n), 24'h1);
    feed(24'h400200);
    chk("res fs", result_data, POS_FULL);
    chk("rdy fs end", 24'(conversion_ready_n), 24'h0);
    host.release_bus();
  endtask : t_fs_cal

  task automatic t_cancel();
    host.select();
    host.send_byte(OP_SELF_CAL);
    wait_busy(1'b1);
    for (int i = 0; i < 3; i++)
      feed(24'h000050);
    host.release_bus();
    wait_busy(1'b0);
    chk("ofs kept", offset_corr_word, 24'h000200);
    host.send_byte(OP_SELF_CAL);
    repeat (10) @(negedge mclk);
    chk("desel", 24'(cal_busy), 24'h0);
  endtask : t_cancel

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #200us;
    n_fail++;
    print_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    start_pin = 1'b0;
    filt_valid = 1'b0;
    filt_data = 24'h000000;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_regs();
    t_conv();
    t_user_cal();
    t_ofs_cal(OP_SYS_CAL, 1'b0);
    t_ofs_cal(OP_SELF_CAL, 1'b1);
    t_fs_cal();
    t_cancel();
    print_verdict();
  end
endmodule : adc_calibration_engine_tb
